//--- rtl/lvmon_top.sv
// supply low-voltage monitor control: apb registers, settle gate, trip flag
// assumes the analog comparator, divider and reference sit outside
`timescale 1ns/1ps
`default_nettype none
`include "lvmon_params.svh"

module lvmon_top #(
    parameter int SETTLE_CYCLES = `LVMON_SETTLE_CYCLES
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog front end
    input  wire logic        comparator_trip,
    input  wire logic        external_trip_input,
    output logic             monitor_power_enable,
    output logic [3:0]       trip_level_select,
    output logic             external_input_select,
    // processor side
    output logic             lowv_irq,
    output logic             lowv_wake,
    output lvmon_pkg::monitor_status_t status
);
    import lvmon_pkg::*;

    monitor_cfg_t   cfg_reg;
    monitor_state_t state_reg;
    logic           flag_reg;
    logic           ie_reg;
    logic           gie_reg;
    logic           trip_sync;
    logic           ref_stable;
    logic           wr_en;
    logic           rd_en;
    logic           hit;
    logic           flag_clear;
    logic           trip_event;
    logic [31:0]    rd_next;

    assign wr_en  = psel && penable && pwrite;
    assign rd_en  = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign hit    = (paddr == `LVMON_CTRL_OFFSET) ||
                    (paddr == `LVMON_FLAG_OFFSET) ||
                    (paddr == `LVMON_IE_OFFSET)   ||
                    (paddr == `LVMON_GIE_OFFSET);
    assign pslverr = psel && penable && !hit;

    // control register: enable and level; stable bit never written
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg.power_enable <= 1'b0;
            cfg_reg.trip_level   <= `LVMON_LEVEL_RESET;
        end else if (wr_en && paddr == `LVMON_CTRL_OFFSET) begin
            cfg_reg.power_enable <= pwdata[`LVMON_EN_BIT];
            cfg_reg.trip_level   <=
                pwdata[`LVMON_LEVEL_MSB:`LVMON_LEVEL_LSB];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ie_reg <= 1'b0;
        end else if (wr_en && paddr == `LVMON_IE_OFFSET) begin
            ie_reg <= pwdata[`LVMON_IE_BIT];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            gie_reg <= 1'b0;
        end else if (wr_en && paddr == `LVMON_GIE_OFFSET) begin
            gie_reg <= pwdata[`LVMON_GIE_BIT];
        end
    end

    // comparator output is asynchronous
    lvmon_sync u_sync (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .async_in (comparator_trip),
        .sync_out (trip_sync)
    );

    lvmon_settle #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_settle (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .enable  (cfg_reg.power_enable),
        .stable  (ref_stable)
    );

    // monitor state: off, waiting for reference, armed
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= MON_OFF;
        end else begin
            case (state_reg)
                MON_OFF: begin
                    if (cfg_reg.power_enable) begin
                        state_reg <= MON_SETTLING;
                    end
                end
                MON_SETTLING: begin
                    if (!cfg_reg.power_enable) begin
                        state_reg <= MON_OFF;
                    end else if (ref_stable) begin
                        state_reg <= MON_ARMED;
                    end
                end
                MON_ARMED: begin
                    if (!cfg_reg.power_enable) begin
                        state_reg <= MON_OFF;
                    end
                end
                default: begin
                    state_reg <= MON_OFF;
                end
            endcase
        end
    end

    // detection only when armed and still enabled and stable
    assign trip_event = (state_reg == MON_ARMED) && cfg_reg.power_enable &&
                        ref_stable && trip_sync;
    assign flag_clear = wr_en && paddr == `LVMON_FLAG_OFFSET &&
                        !pwdata[`LVMON_FLAG_BIT];

    // sticky flag, set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
        end else if (trip_event) begin
            flag_reg <= 1'b1;
        end else if (flag_clear) begin
            flag_reg <= 1'b0;
        end
    end

    // analog side drives; clock keeps running in sleep for this logic
    assign monitor_power_enable  = cfg_reg.power_enable;
    assign trip_level_select     = cfg_reg.trip_level;
    assign external_input_select = cfg_reg.power_enable &&
        (cfg_reg.trip_level == `LVMON_LEVEL_EXTERNAL);

    assign lowv_irq  = flag_reg && ie_reg && gie_reg;
    assign lowv_wake = flag_reg && ie_reg;

    assign status.reference_stable    = ref_stable;
    assign status.lowv_interrupt_flag = flag_reg;
    assign status.irq                 = lowv_irq;
    assign status.wake                = lowv_wake;

    // read mux
    always_comb begin
        rd_next = 32'h0000_0000;
        case (paddr)
            `LVMON_CTRL_OFFSET: begin
                rd_next[`LVMON_STABLE_BIT] = ref_stable;
                rd_next[`LVMON_EN_BIT]     = cfg_reg.power_enable;
                rd_next[`LVMON_LEVEL_MSB:`LVMON_LEVEL_LSB] = cfg_reg.trip_level;
            end
            `LVMON_FLAG_OFFSET: begin
                rd_next[`LVMON_FLAG_BIT] = flag_reg;
            end
            `LVMON_IE_OFFSET: begin
                rd_next[`LVMON_IE_BIT] = ie_reg;
            end
            `LVMON_GIE_OFFSET: begin
                rd_next[`LVMON_GIE_BIT] = gie_reg;
            end
            default: begin
                rd_next = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_next;
        end
    end
endmodule : lvmon_top
`default_nettype wire

//--- rtl/lvmon_params.svh
// offsets, field positions, reset values and timing counts of the monitor
// assumes a 10 MHz system clock and a 32-bit apb register slave
`ifndef LVMON_PARAMS_SVH
`define LVMON_PARAMS_SVH

`define LVMON_CTRL_OFFSET      12'h000
`define LVMON_FLAG_OFFSET      12'h004
`define LVMON_IE_OFFSET        12'h008
`define LVMON_GIE_OFFSET       12'h00c

`define LVMON_LEVEL_LSB        0
`define LVMON_LEVEL_MSB        3
`define LVMON_EN_BIT           4
`define LVMON_STABLE_BIT       5
`define LVMON_FLAG_BIT         2
`define LVMON_IE_BIT           2
`define LVMON_GIE_BIT          7

`define LVMON_LEVEL_RESET      4'h5
`define LVMON_LEVEL_EXTERNAL   4'hf

`define LVMON_CLK_HZ           10000000
`define LVMON_SETTLE_US        20
`define LVMON_SETTLE_CYCLES    ((`LVMON_SETTLE_US * `LVMON_CLK_HZ) / 1000000)

`endif

//--- rtl/lvmon_pkg.sv
// types shared by the supply monitor files
// assumes lvmon_params.svh for the numbers
package lvmon_pkg;
    typedef struct packed {
        logic       power_enable;
        logic [3:0] trip_level;
    } monitor_cfg_t;

    typedef struct packed {
        logic reference_stable;
        logic lowv_interrupt_flag;
        logic irq;
        logic wake;
    } monitor_status_t;

    typedef enum logic [1:0] {
        MON_OFF      = 2'b00,
        MON_SETTLING = 2'b01,
        MON_ARMED    = 2'b10
    } monitor_state_t;
endpackage : lvmon_pkg

//--- rtl/lvmon_sync.sv
// two-flop synchroniser for the asynchronous comparator output
// assumes one system clock and an active-low asynchronous reset
`timescale 1ns/1ps
`default_nettype none
module lvmon_sync (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // level in and out
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : lvmon_sync
`default_nettype wire

//--- rtl/lvmon_settle.sv
// reference settling timer: counts while enabled, reports stable at terminal
// assumes enable is synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "lvmon_params.svh"
module lvmon_settle #(
    parameter int SETTLE_CYCLES = `LVMON_SETTLE_CYCLES
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // control and result
    input  wire logic enable,
    output logic      stable
);
    localparam int CW = $clog2(SETTLE_CYCLES + 1);
    logic [CW-1:0] count_reg;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
            stable    <= 1'b0;
        end else if (!enable) begin
            count_reg <= '0;
            stable    <= 1'b0;
        end else if (count_reg == CW'(SETTLE_CYCLES)) begin
            stable    <= 1'b1;
        end else begin
            count_reg <= count_reg + CW'(1);
        end
    end
endmodule : lvmon_settle
`default_nettype wire

//--- testbench/lvmon_monitor.sv
// concurrent checks on the supply monitor control block ports
// assumes one clock domain and a bind onto lvmon_top
`timescale 1ns/1ps
`default_nettype none
module lvmon_monitor #(
    parameter int SETTLE_CYCLES = 5
) (
    // clock and reset
    input wire logic                      sys_clk,
    input wire logic                      rst_n,
    // apb
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [11:0]               paddr,
    input wire logic [31:0]               pwdata,
    // front end and processor side
    input wire logic                      comparator_trip,
    input wire logic                      monitor_power_enable,
    input wire logic [3:0]                trip_level_select,
    input wire logic                      external_input_select,
    input wire logic                      lowv_irq,
    input wire logic                      lowv_wake,
    input wire lvmon_pkg::monitor_status_t status
);
    import lvmon_pkg::*;
    logic       acc;
    logic [4:0] wr_ctl;
    int         en_cnt;
    assign acc = psel && penable && pwrite;
    assign wr_ctl = pwdata[4:0];
    // cycles spent enabled, saturating
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            en_cnt <= 0;
        else if (!monitor_power_enable)
            en_cnt <= 0;
        else if (en_cnt < 1000)
            en_cnt <= en_cnt + 1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    settle_early_a: assert property (
        status.reference_stable |-> en_cnt >= SETTLE_CYCLES - 1)
        else $error("stable before settling");
    settle_late_a: assert property (
        en_cnt >= SETTLE_CYCLES + 3 |-> status.reference_stable)
        else $error("stable missing after settling");
    flag_gate_a: assert property (
        $rose(status.lowv_interrupt_flag) |-> $past(status.reference_stable))
        else $error("flag set while not stable");
    trip_sets_a: assert property (
        (comparator_trip && status.reference_stable) [*4]
        |-> status.lowv_interrupt_flag)
        else $error("trip did not set flag");
    flag_hold_a: assert property (
        status.lowv_interrupt_flag && !(acc && paddr == 12'h004 && !pwdata[2])
        |=> status.lowv_interrupt_flag)
        else $error("flag lost without clear");
    irq_cause_a: assert property (
        lowv_irq |-> lowv_wake && status.lowv_interrupt_flag)
        else $error("irq without flag and enable");
    wake_cause_a: assert property (
        lowv_wake |-> status.lowv_interrupt_flag)
        else $error("wake without flag");
    ext_route_a: assert property (
        external_input_select ==
        (monitor_power_enable && trip_level_select == 4'hf))
        else $error("external route wrong");
    ctrl_write_a: assert property (
        acc && paddr == 12'h000 |=> {monitor_power_enable,
        trip_level_select} == $past(wr_ctl))
        else $error("control write not applied");
    cover property ($rose(status.reference_stable));
    cover property ($rose(lowv_irq));
    cover property ($rose(external_input_select));
endmodule : lvmon_monitor

bind lvmon_top lvmon_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_mon (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .comparator_trip, .monitor_power_enable, .trip_level_select,
    .external_input_select, .lowv_irq, .lowv_wake, .status);
`default_nettype wire

//--- testbench/supply_low_voltage_detect_control_bench.sv
// self-checking bench for the supply monitor control block
// assumes lvmon_top with a short settling count, apb master here
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module supply_low_voltage_detect_control_bench;
    import lvmon_pkg::*;
    localparam int SETTLE = 5;
    logic            sys_clk, rst_n, psel, penable, pwrite, trip, ext_in;
    logic            pready, pslverr, err, pwr_en, ext_sel, irq, wake;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic [3:0]      lvl;
    monitor_status_t status;
    int              bad_count, n_tests, cycles;

    lvmon_top #(.SETTLE_CYCLES(SETTLE)) dut (
        .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .comparator_trip(trip),
        .external_trip_input(ext_in), .monitor_power_enable(pwr_en),
        .trip_level_select(lvl), .external_input_select(ext_sel),
        .lowv_irq(irq), .lowv_wake(wake), .status);

    task automatic complete_run;
        if (bad_count == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rd_chk

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            complete_run();
        end
    end

    initial begin
        {rst_n, psel, penable, pwrite, trip, ext_in} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        tick(12);
        rst_n <= 1'b1;
        rd_chk(12'h000, 32'h5);
        rd_chk(12'h004, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        // trip while off must not flag
        trip <= 1'b1;
        tick(8);
        `CHK(status.lowv_interrupt_flag, 1'b0)
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h000, 32'h2f);
        apb(1'b1, 12'h000, 32'h3f);
        rd_chk(12'h000, 32'h1f);
        `CHK(status.lowv_interrupt_flag, 1'b0)
        for (int k = 0; k < 20 && rd[5] !== 1'b1; k++)
            apb(1'b0, 12'h000, 32'h0);
        `CHK({rd, ext_sel}, {32'h3f, 1'b1})
        tick(4);
        rd_chk(12'h004, 32'h4);
        `CHK(irq, 1'b0)
        apb(1'b1, 12'h008, 32'h4);
        tick(1);
        `CHK({irq, wake}, 2'b01)
        apb(1'b1, 12'h00c, 32'h80);
        tick(1);
        `CHK({irq, wake}, 2'b11)
        trip <= 1'b0;
        apb(1'b1, 12'h004, 32'h4);
        tick(6);
        `CHK(status.lowv_interrupt_flag, 1'b1)
        apb(1'b1, 12'h004, 32'h0);
        tick(1);
        `CHK({irq, status.lowv_interrupt_flag}, 2'b00)
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, 12'h000, 32'h10 | i);
            tick(1);
            `CHK({lvl, ext_sel}, {i[3:0], i == 15})
        end
        apb(1'b1, 12'h000, 32'h0);
        ext_in <= 1'b1;
        trip <= 1'b1;
        tick(8);
        `CHK({pwr_en, status.lowv_interrupt_flag}, 2'b00)
        rd_chk(12'h000, 32'h0);
        apb(1'b1, 12'h000, 32'h1a);
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        rd_chk(12'h000, 32'h5);
        rd_chk(12'h00c, 32'h0);
        complete_run();
    end
endmodule : supply_low_voltage_detect_control_bench
`undef CHK
`default_nettype wire
